// *** logic/aoc_conv_pipe.sv ***
// Purpose: Gain, saturation, coding and three-stage result pipeline
// Assumes: edge_i pulses once per sample clock rising edge
// Notes:   Output updates on the third edge after the capture edge
`timescale 1ns/1ps
module aoc_conv_pipe (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  edge_i,
  input  wire logic                                  en_i,
  input  wire logic signed [aoc_pkg::VP_W-1:0]       vp_i,
  input  wire logic        [aoc_pkg::GAIN_W-1:0]     gain_i,
  input  wire logic                                  twos_i,
  output aoc_pkg::aoc_res_s                          res_o,
  output logic                                       res_vld_o
);

  aoc_pkg::aoc_pipe_st_s               st_reg;
  aoc_pkg::aoc_pipe_st_s               st_next;
  logic signed [aoc_pkg::CONV_W-1:0]   prod;
  logic signed [aoc_pkg::CONV_W-1:0]   sum;
  logic        [3:0]                   gfac;
  aoc_pkg::aoc_res_s                   conv;

  always_comb begin
    // Gain is (code + 1) / 2: 0.5 .. 4.0 in steps of 0.5
    gfac = {1'b0, gain_i} + 4'h1;
    prod = vp_i * $signed({1'b0, gfac});
    sum  = (prod >>> 1) + aoc_pkg::MID_S;
    conv.over_range_flag = sum[aoc_pkg::CONV_W-1] || (sum > aoc_pkg::MAX_S);
    if (sum[aoc_pkg::CONV_W-1]) begin
      conv.code = aoc_pkg::CODE_MIN;
    end else if (sum > aoc_pkg::MAX_S) begin
      conv.code = aoc_pkg::CODE_MAX;
    end else begin
      conv.code = sum[aoc_pkg::DATA_W-1:0];
    end
    if (twos_i) begin
      conv.code = conv.code ^ aoc_pkg::MSB_FLIP;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.out_vld = 1'b0;
    if (edge_i && en_i) begin
      // Capture now, shift older samples one stage on
      st_next.stg[0] = conv;
      st_next.vld[0] = 1'b1;
      for (int i = 1; i < aoc_pkg::PIPE_N; i++) begin
        st_next.stg[i] = st_reg.stg[i-1];
        st_next.vld[i] = st_reg.vld[i-1];
      end
      if (st_reg.vld[aoc_pkg::PIPE_N-1]) begin
        st_next.out     = st_reg.stg[aoc_pkg::PIPE_N-1];
        st_next.out_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign res_o     = st_reg.out;
  assign res_vld_o = st_reg.out_vld;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Coding was fixed at capture, so either coding of a limit is accepted here
  sat_limits_a: assert property (res_vld_o && res_o.over_range_flag
                                 |-> (res_o.code & ~aoc_pkg::MSB_FLIP) == aoc_pkg::CODE_MIN
                                 || (res_o.code | aoc_pkg::MSB_FLIP) == aoc_pkg::CODE_MAX)
    else $error("over-range result not saturated");
  pipe_latency_a: assert property (edge_i && en_i && st_reg.vld[aoc_pkg::PIPE_N-1]
                                   |=> res_vld_o && res_o == $past(st_reg.stg[aoc_pkg::PIPE_N-1]))
    else $error("pipeline output is not the oldest stage");
  twos_mid_a: assert property (edge_i && en_i && twos_i && sum == aoc_pkg::MID_S
                               |=> st_reg.stg[0].code == aoc_pkg::CODE_MIN)
    else $error("midscale not coded as zero in twos complement");
  out_on_edge_a: assert property (res_vld_o |-> $past(edge_i) && $past(en_i))
    else $error("result appeared without a sample edge");

endmodule

// *** logic/aoc_ctrl_port.sv ***
// Purpose: Control register file written from the shared bus or from software
// Assumes: Host writes only while output drivers are released
// Notes:   Bits 9:8 of a host word select control, clamp level low or high part
`timescale 1ns/1ps
module aoc_ctrl_port (
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            oe_n_i,
  input  wire logic                            wr_i,
  input  wire logic [aoc_pkg::DATA_W-1:0]      bus_i,
  input  wire logic                            sw_ctrl_we_i,
  input  aoc_pkg::aoc_ctrl_s                   sw_ctrl_i,
  input  wire logic [1:0]                      sw_dac_we_i,
  input  wire logic [aoc_pkg::DATA_W-1:0]      sw_dac_i,
  output aoc_pkg::aoc_ctrl_s                   ctrl_o,
  output logic      [aoc_pkg::DATA_W-1:0]      dac_o,
  output logic                                 hwr_o
);

  aoc_pkg::aoc_cport_st_s st_reg;
  aoc_pkg::aoc_cport_st_s st_next;
  logic                   hw_take;

  always_comb begin
    st_next = st_reg;
    st_next.wr_prev = wr_i;
    // Software writes first; a host strobe in the same cycle wins
    if (sw_ctrl_we_i) begin
      st_next.ctrl = sw_ctrl_i;
    end
    if (sw_dac_we_i[0]) begin
      st_next.dac[7:0] = sw_dac_i[7:0];
    end
    if (sw_dac_we_i[1]) begin
      st_next.dac[9:8] = sw_dac_i[9:8];
    end
    // Word is taken on the strobe's rising edge, only with drivers off
    hw_take = wr_i && !st_reg.wr_prev && oe_n_i;
    st_next.hwr = hw_take;
    if (hw_take) begin
      case (bus_i[aoc_pkg::SEL_LSB +: 2])
        aoc_pkg::SEL_CTRL: begin
          st_next.ctrl = bus_i[aoc_pkg::PWDN_BIT:aoc_pkg::GAIN_LSB];
        end
        aoc_pkg::SEL_DAC_LO: begin
          st_next.dac[7:0] = bus_i[7:0];
        end
        aoc_pkg::SEL_DAC_HI: begin
          st_next.dac[9:8] = bus_i[1:0];
        end
        default: begin
          st_next.hwr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '{wr_prev: 1'b0, ctrl: aoc_pkg::CTRL_RST, dac: aoc_pkg::DAC_RST, hwr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl_o = st_reg.ctrl;
  assign dac_o  = st_reg.dac;
  assign hwr_o  = st_reg.hwr;

  default clocking cb @(posedge clk_i); endclocking

  gain_reset_a: assert property (@(posedge clk_i) $past(rst_i) && !rst_i |-> ctrl_o.gain == aoc_pkg::GAIN_RST
                                 && !ctrl_o.clamp_dac)
    else $error("gain or clamp source wrong after reset");
  host_write_a: assert property (disable iff (rst_i) wr_i && !st_reg.wr_prev && oe_n_i
                                 && bus_i[9:8] == aoc_pkg::SEL_CTRL
                                 |=> ctrl_o == $past(bus_i[5:0]))
    else $error("host control word not stored");
  no_write_driving_a: assert property (disable iff (rst_i) !oe_n_i && !sw_ctrl_we_i |=> $stable(ctrl_o))
    else $error("control changed while drivers enabled");

endmodule

// *** logic/aoc_pkg.sv ***
// Purpose: Shared constants and types for the converter output and control port
// Assumes: One 250 MHz clock; all pin inputs synchronous to it
// Notes:   Control word fields sit at the bit positions given below
package aoc_pkg;

  localparam int unsigned DATA_W   = 10;
  localparam int unsigned GAIN_W   = 3;
  localparam int unsigned VP_W     = 16;
  localparam int unsigned PIPE_N   = 3;
  localparam int unsigned CONV_W   = 21;

  // Codes and limits of the converter core
  localparam logic [DATA_W-1:0]        CODE_MIN = 10'h000;
  localparam logic [DATA_W-1:0]        CODE_MAX = 10'h3ff;
  localparam logic [DATA_W-1:0]        MSB_FLIP = 10'h200;
  localparam logic signed [CONV_W-1:0] MID_S    = 21'sh000200;
  localparam logic signed [CONV_W-1:0] MAX_S    = 21'sh0003ff;

  // Control word layout on the shared bus
  localparam int unsigned GAIN_LSB     = 0;
  localparam int unsigned FMT_BIT      = 3;
  localparam int unsigned CLAMP_BIT    = 4;
  localparam int unsigned PWDN_BIT     = 5;
  localparam int unsigned SEL_LSB      = 8;
  localparam logic [1:0]  SEL_CTRL     = 2'h0;
  localparam logic [1:0]  SEL_DAC_LO   = 2'h1;
  localparam logic [1:0]  SEL_DAC_HI   = 2'h2;

  // Values after reset: unity gain, straight binary, pin clamp level, running
  localparam logic [GAIN_W-1:0] GAIN_RST = 3'h1;
  localparam logic [DATA_W-1:0] DAC_RST  = 10'h000;

  // Wishbone register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_DAC   = 8'h04;
  localparam logic [7:0] OFS_RES   = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;

  // Interrupt bits
  localparam int unsigned IRQ_N    = 3;
  localparam int unsigned IRQ_SMP  = 0;
  localparam int unsigned IRQ_OVR  = 1;
  localparam int unsigned IRQ_HWR  = 2;

  typedef struct packed {
    logic              pwdn;
    logic              clamp_dac;
    logic              twos;
    logic [GAIN_W-1:0] gain;
  } aoc_ctrl_s;

  localparam aoc_ctrl_s CTRL_RST = '{pwdn: 1'b0, clamp_dac: 1'b0, twos: 1'b0, gain: GAIN_RST};

  typedef struct packed {
    logic              over_range_flag;
    logic [DATA_W-1:0] code;
  } aoc_res_s;

  typedef struct packed {
    logic [PIPE_N-1:0]           vld;
    aoc_res_s [PIPE_N-1:0]       stg;
    aoc_res_s                    out;
    logic                        out_vld;
  } aoc_pipe_st_s;

  typedef struct packed {
    logic              wr_prev;
    aoc_ctrl_s         ctrl;
    logic [DATA_W-1:0] dac;
    logic              hwr;
  } aoc_cport_st_s;

  typedef struct packed {
    logic              sclk_prev;
    logic [DATA_W-1:0] bus;
    logic              oe_n;
    logic              over_range_flag;
    logic              clamp_drive;
    aoc_res_s          last;
    logic [IRQ_N-1:0]  istat;
    logic [IRQ_N-1:0]  imask;
    logic              irq;
    logic              ack;
    logic [31:0]       rdat;
  } aoc_top_st_s;

endpackage

// *** logic/aoc_top.sv ***
// Purpose: Digital output and control port of a 10-bit sampling converter
// Assumes: Sample clock, enable, strobe and bus inputs are synchronous to clk_i
// Notes:   Software sees the same control state over classic Wishbone
//
// How it works
// - Capture on each sample clock rise unless powered down; result shows after third later rise.
// - Bus drivers turn off whenever the active-low enable is deasserted.
// - With the enable pin deasserted, a write strobe stores the bus word in control or clamp level, as bits 9:8 select.
// - Control sets clamp, output coding, gain and power-down.
// - Over-range flag goes high when amplified input is outside full scale.
// - Below negative full scale the code is zero in straight binary, 512 with twos coding.
// - Above positive full scale the code is 1023 in straight binary, 511 with twos coding.
// - Gain resets to one, programmable from one half to four.
// - Clamp level comes from the 10-bit DAC or the level pin.
// - After reset the clamp level pin is the reference.
// - Gain is a three-bit field in steps of one half.
// - Clamp gate high forces the input to the selected clamp level.
`timescale 1ns/1ps
module aoc_top (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Wishbone slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [7:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  output logic                                     irq_o,
  // Converter side
  input  wire logic                                sample_clk_i,
  input  wire logic signed [aoc_pkg::VP_W-1:0]     analog_i,
  input  wire logic                                clamp_gate_i,
  output logic                                     clamp_drive_o,
  output logic                                     clamp_use_dac_o,
  output logic      [aoc_pkg::DATA_W-1:0]          clamp_dac_o,
  output logic      [aoc_pkg::GAIN_W-1:0]          gain_o,
  output logic                                     power_down_o,
  // Shared data bus
  input  wire logic                                oe_n_i,
  input  wire logic                                wr_i,
  input  wire logic [aoc_pkg::DATA_W-1:0]          shared_data_bus_i,
  output logic      [aoc_pkg::DATA_W-1:0]          shared_data_bus_o,
  output logic                                     shared_data_bus_oe_n_o,
  output logic                                     over_range_flag_o
);

  aoc_pkg::aoc_top_st_s   st_reg;
  aoc_pkg::aoc_top_st_s   st_next;
  aoc_pkg::aoc_ctrl_s     ctrl;
  aoc_pkg::aoc_ctrl_s     sw_ctrl;
  aoc_pkg::aoc_res_s      res;
  logic                   res_vld;
  logic                   hwr;
  logic                   sedge;
  logic                   wb_req;
  logic                   wb_wr;
  logic                   sw_ctrl_we;
  logic [1:0]             sw_dac_we;
  logic [aoc_pkg::IRQ_N-1:0] ev;
  logic [aoc_pkg::IRQ_N-1:0] clr;

  aoc_conv_pipe u_pipe (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .edge_i    (sedge),
    .en_i      (!ctrl.pwdn),
    .vp_i      (analog_i),
    .gain_i    (ctrl.gain),
    .twos_i    (ctrl.twos),
    .res_o     (res),
    .res_vld_o (res_vld)
  );

  aoc_ctrl_port u_cport (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .oe_n_i       (oe_n_i),
    .wr_i         (wr_i),
    .bus_i        (shared_data_bus_i),
    .sw_ctrl_we_i (sw_ctrl_we),
    .sw_ctrl_i    (sw_ctrl),
    .sw_dac_we_i  (sw_dac_we),
    .sw_dac_i     (wb_dat_i[aoc_pkg::DATA_W-1:0]),
    .ctrl_o       (ctrl),
    .dac_o        (clamp_dac_o),
    .hwr_o        (hwr)
  );

  // Bus write lands on the edge at which ack is high
  assign sedge      = sample_clk_i && !st_reg.sclk_prev;
  assign wb_req     = wb_cyc_i && wb_stb_i;
  assign wb_wr      = wb_req && wb_we_i && st_reg.ack;
  assign sw_ctrl    = wb_dat_i[aoc_pkg::PWDN_BIT:aoc_pkg::GAIN_LSB];
  assign sw_ctrl_we = wb_wr && wb_sel_i[0] && (wb_adr_i == aoc_pkg::OFS_CTRL);
  assign sw_dac_we  = (wb_wr && (wb_adr_i == aoc_pkg::OFS_DAC)) ? wb_sel_i[1:0] : 2'h0;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_prev = sample_clk_i;
    // Drivers follow the enable pin; power-down also releases them
    st_next.oe_n = oe_n_i || ctrl.pwdn;
    if (res_vld) begin
      st_next.bus  = res.code;
      st_next.over_range_flag  = res.over_range_flag;
      st_next.last = res;
    end
    st_next.clamp_drive = clamp_gate_i;

    // Sticky events: new sample, over-range, any host word taken from the shared bus
    ev = '0;
    ev[aoc_pkg::IRQ_SMP] = res_vld;
    ev[aoc_pkg::IRQ_OVR] = res_vld && res.over_range_flag;
    ev[aoc_pkg::IRQ_HWR] = hwr;
    clr = '0;
    if (wb_wr && wb_sel_i[0] && (wb_adr_i == aoc_pkg::OFS_ISTAT)) begin
      clr = wb_dat_i[aoc_pkg::IRQ_N-1:0];
    end
    if (wb_wr && wb_sel_i[0] && (wb_adr_i == aoc_pkg::OFS_IMASK)) begin
      st_next.imask = wb_dat_i[aoc_pkg::IRQ_N-1:0];
    end
    // A set in the clearing cycle survives
    st_next.istat = (st_reg.istat & ~clr) | ev;
    st_next.irq   = |(st_next.istat & st_next.imask);

    // Classic single-cycle answer: ack one cycle after the request, then drop
    st_next.ack = wb_req && !st_reg.ack;
    if (wb_req && !st_reg.ack) begin
      case (wb_adr_i)
        aoc_pkg::OFS_CTRL:  st_next.rdat = {26'h0, ctrl};
        aoc_pkg::OFS_DAC:   st_next.rdat = {22'h0, clamp_dac_o};
        aoc_pkg::OFS_RES:   st_next.rdat = {21'h0, st_reg.last};
        aoc_pkg::OFS_ISTAT: st_next.rdat = {29'h0, st_reg.istat};
        aoc_pkg::OFS_IMASK: st_next.rdat = {29'h0, st_reg.imask};
        default:            st_next.rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.oe_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign shared_data_bus_o      = st_reg.bus;
  assign shared_data_bus_oe_n_o = st_reg.oe_n;
  assign over_range_flag_o      = st_reg.over_range_flag;
  assign clamp_drive_o          = st_reg.clamp_drive;
  assign clamp_use_dac_o        = ctrl.clamp_dac;
  assign gain_o                 = ctrl.gain;
  assign power_down_o           = ctrl.pwdn;
  assign irq_o                  = st_reg.irq;
  assign wb_ack_o               = st_reg.ack;
  assign wb_dat_o               = st_reg.rdat;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  drivers_off_a: assert property (oe_n_i |=> shared_data_bus_oe_n_o)
    else $error("bus driven while enable deasserted");
  clamp_follow_a: assert property (1'b1 |=> clamp_drive_o == $past(clamp_gate_i))
    else $error("clamp drive does not follow the gate");
  ovr_flag_a: assert property (res_vld && res.over_range_flag |=> over_range_flag_o)
    else $error("over-range flag not raised");
  irq_level_a: assert property (irq_o == |(st_reg.istat & st_reg.imask))
    else $error("interrupt output disagrees with status and mask");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  bus_result_a: assert property (res_vld
                                 |=> shared_data_bus_o == $past(res.code) && over_range_flag_o == $past(res.over_range_flag))
    else $error("result not presented on the bus");

endmodule

// *** sim/aoc_host_model.sv ***
// Purpose: Host side of the shared bus: sample clock, drive enable, write strobe
// Assumes: Tasks are called by the bench right after a rising clk_i edge
// Notes:   A bus nobody drives shows the inverse of its last level
`timescale 1ns/1ps
module aoc_host_model (
  input  wire logic                       clk_i,
  input  wire logic [aoc_pkg::DATA_W-1:0] dev_bus_i,
  input  wire logic                       dev_oe_n_i,
  output logic                            sample_clk_o,
  output logic                            oe_n_o,
  output logic                            wr_o,
  output logic      [aoc_pkg::DATA_W-1:0] wire_o
);
  logic                       drv;
  logic [aoc_pkg::DATA_W-1:0] word;
  logic [aoc_pkg::DATA_W-1:0] last;

  initial begin
    sample_clk_o = 1'b0;
    oe_n_o = 1'b0;
    wr_o = 1'b0;
    drv = 1'b0;
    word = 10'h000;
    last = 10'h000;
  end

  // Device drivers win the wire when enabled
  assign wire_o = !dev_oe_n_i ? dev_bus_i : (drv ? word : ~last);

  always @(posedge clk_i) begin
    last <= wire_o;
  end

  // Ten clocks a period keep the sample clock at 25 MHz
  task automatic sample();
    @(posedge clk_i);
    sample_clk_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    sample_clk_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // Release drivers, put the word out, strobe it, then enable drivers again
  task automatic write_word(input logic [aoc_pkg::DATA_W-1:0] w, input logic rel);
    @(posedge clk_i);
    oe_n_o <= rel;
    repeat (3) @(posedge clk_i);
    drv <= 1'b1;
    word <= w;
    @(posedge clk_i);
    wr_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
    drv <= 1'b0;
    repeat (3) @(posedge clk_i);
    oe_n_o <= 1'b0;
  endtask
endmodule

// *** sim/aoc_top_test.sv ***
// Purpose: Self-checking bench for the converter output and control port
// Assumes: Host model drives the shared bus side, bench drives Wishbone
// Notes:   Driver queues expected results, a monitor pops them as they appear
`timescale 1ns/1ps
module aoc_top_test;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        dat = 32'h0;
  logic signed [15:0] analog = 16'sh0000;
  logic               gate = 1'b0;
  wire  [31:0]        wb_dat_o;
  wire                ack, irq, cdrive, cuse, pwdn, sclk, oe_n, wr, dbus_oe_n, over_range_flag;
  wire  [9:0]         cdac, dbus_o, bus_wire;
  wire  [2:0]         gain;
  int                 err_count = 0;
  int                 samples_checked = 0;
  int                 cnt = 0;
  int                 g = 1;
  bit                 tw = 1'b0;
  bit                 mon_on = 1'b1;
  logic [10:0]        exp_q[$];
  logic [10:0]        last_exp;
  logic [10:0]        e;
  logic [31:0]        rd;
  logic [31:0]        seed = 32'hd3abe50c;
  int                 bnd[8] = '{511, 512, -512, -513, 0, 1000, -1000, 100};

  always #2 clk_i = ~clk_i;

  aoc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
    .irq_o(irq), .sample_clk_i(sclk), .analog_i(analog), .clamp_gate_i(gate),
    .clamp_drive_o(cdrive), .clamp_use_dac_o(cuse), .clamp_dac_o(cdac), .gain_o(gain),
    .power_down_o(pwdn), .oe_n_i(oe_n), .wr_i(wr), .shared_data_bus_i(bus_wire),
    .shared_data_bus_o(dbus_o), .shared_data_bus_oe_n_o(dbus_oe_n), .over_range_flag_o(over_range_flag));

  aoc_host_model host (.clk_i(clk_i), .dev_bus_i(dbus_o), .dev_oe_n_i(dbus_oe_n),
    .sample_clk_o(sclk), .oe_n_o(oe_n), .wr_o(wr), .wire_o(bus_wire));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Gain as (code+1)/2, saturate to the code range, flag saturation
  function automatic logic [10:0] calc(input int a, input int gc, input bit t);
    int v;
    logic [10:0] r;
    v = ((a * (gc + 1)) >>> 1) + 512;
    r = (v < 0) ? 11'h400 : (v > 1023) ? 11'h7ff : {1'b0, v[9:0]};
    r[9] = r[9] ^ t;
    return r;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_sim();
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic smp(input int a);
    analog <= 16'(a);
    exp_q.push_back(calc(a, g, tw));
    host.sample();
  endtask

  // Result of capture n shows after the third later capture edge
  initial begin
    forever begin
      @(posedge sclk);
      if (mon_on) begin
        cnt++;
        if (cnt >= 4) begin
          repeat (6) @(posedge clk_i);
          e = exp_q.pop_front();
          last_exp = e;
          check({over_range_flag, bus_wire}, e);
          check(dbus_oe_n, 1'b0);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(gain, 3'h1);
    check(cuse, 1'b0);
    check({pwdn, irq, cdac}, 12'h000);
    wb(1'b0, aoc_pkg::OFS_CTRL, 32'h0, rd);
    check(rd, 32'h1);
    wb(1'b0, 8'h14, 32'h0, rd);
    check(rd, 32'h0);
    foreach (bnd[i]) smp(bnd[i]);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      if (i % 4 == 0) begin
        g = seed[14:12];
        tw = seed[15];
        wb(1'b1, aoc_pkg::OFS_CTRL, {28'h0, tw, g[2:0]}, rd);
      end
      smp($signed(seed[10:0]));
    end
    // Flush with twos coding on so midscale captures exercise that coding
    tw = 1'b1;
    wb(1'b1, aoc_pkg::OFS_CTRL, {28'h0, tw, g[2:0]}, rd);
    repeat (3) smp(0);
    mon_on = 1'b0;
    wb(1'b0, aoc_pkg::OFS_RES, 32'h0, rd);
    check(rd, {21'h0, last_exp});
    wb(1'b0, aoc_pkg::OFS_ISTAT, 32'h0, rd);
    check(rd, 32'h3);
    wb(1'b0, aoc_pkg::OFS_CTRL, 32'h0, rd);
    check(rd, {28'h0, tw, g[2:0]});
    for (int k = 0; k < 8; k++) begin
      host.write_word(10'(k), 1'b1);
      check(gain, k);
    end
    host.write_word(10'h01d, 1'b1);
    check({cuse, gain}, 4'hd);
    host.write_word(10'h003, 1'b0);
    host.write_word(10'h307, 1'b1);
    check(gain, 3'h5);
    host.write_word(10'h1a5, 1'b1);
    host.write_word(10'h203, 1'b1);
    check(cdac, 10'h3a5);
    wb(1'b1, aoc_pkg::OFS_ISTAT, 32'h7, rd);
    wb(1'b0, aoc_pkg::OFS_ISTAT, 32'h0, rd);
    check(rd, 32'h0);
    host.write_word(10'h001, 1'b1);
    wb(1'b0, aoc_pkg::OFS_ISTAT, 32'h0, rd);
    check(rd, 32'h4);
    check(irq, 1'b0);
    wb(1'b1, aoc_pkg::OFS_IMASK, 32'h4, rd);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b1);
    wb(1'b1, aoc_pkg::OFS_ISTAT, 32'h4, rd);
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0);
    gate <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(cdrive, 1'b1);
    gate <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(cdrive, 1'b0);
    host.write_word(10'h021, 1'b1);
    repeat (3) @(posedge clk_i);
    check({pwdn, dbus_oe_n}, 2'h3);
    wb(1'b1, aoc_pkg::OFS_CTRL, 32'h1, rd);
    repeat (2) @(posedge clk_i);
    check(pwdn, 1'b0);
    end_sim();
  end
endmodule
